// file: health_log_chk.sv
module health_log_chk
   import health_log_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Snapshot sources
   input wire logic [TEMP_W-1:0] warning_temp_threshold,
   input wire logic [TEMP_W-1:0] critical_temp_threshold,
   input wire logic [SENSOR_COUNT-1:0] sensor_present,
   input wire logic [SENSOR_COUNT*TEMP_W-1:0] sensor_temp,
   // Log page read port
   input wire logic page_rd,
   input wire logic [BYTE_ADDR_W-1:0] page_addr,
   input wire logic [7:0] page_data,
   input wire logic page_valid
);
   // ==========================================================
   // Settling helpers, since the page lags its sources by a sweep
   logic [99:0] cfg;
   logic [99:0] cfg_q;
   logic [5:0] up_cnt;
   logic [5:0] quiet;
   logic [8:0] off;
   logic [7:0] exp_sensor;
   logic settled;
   assign cfg = {warning_temp_threshold, critical_temp_threshold, sensor_present, sensor_temp};
   assign off = page_addr - 9'h0C8;
   assign exp_sensor = sensor_present[off[2:1]] ? sensor_temp[{off[2:1], off[0], 3'h0} +: 8] : 8'h00;
   assign settled = up_cnt > 6'h23 && quiet > 6'h23;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         up_cnt <= 6'h00;
      end else if (up_cnt != 6'h3F) begin
         up_cnt <= up_cnt + 6'h01;
      end
   end
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= '0;
         quiet <= 6'h00;
      end else begin
         cfg_q <= cfg;
         if (cfg != cfg_q) begin
            quiet <= 6'h00;
         end else if (quiet != 6'h3F) begin
            quiet <= quiet + 6'h01;
         end
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);
   sequence s_req;
      page_rd;
   endsequence
   sequence s_answer;
      ##2 page_valid;
   endsequence
   chk_answer_delay: assert property (s_req |-> s_answer)
      else $error("page answer not two cycles after request");
   chk_no_stray: assert property (page_valid |-> $past(page_rd, 2))
      else $error("page answer without request");
   chk_valid_single: assert property (s_req ##1 !page_rd [*2] |-> ##1 !page_valid)
      else $error("page answer longer than one cycle");
   chk_data_holds: assert property (!page_valid |-> $stable(page_data))
      else $error("page data moved without answer");
   chk_reset_quiet: assert property (disable iff (1'b0) !arst_n |-> !page_valid && page_data == 8'h00)
      else $error("page outputs not cleared in reset");
   chk_blank_bytes: assert property (settled && page_rd && (page_addr < 9'h040
      || page_addr > 9'h0CF) |-> ##2 page_data == 8'h00)
      else $error("unlisted byte not zero");
   chk_sensor_value: assert property (settled && page_rd && page_addr > 9'h0C7
      && page_addr < 9'h0D0 |-> ##2 page_data == $past(exp_sensor, 2))
      else $error("sensor byte wrong");
   chk_warn_zeroed: assert property (settled && page_rd && page_addr > 9'h0BF
      && page_addr < 9'h0C4
      && (warning_temp_threshold == 16'h0000 || critical_temp_threshold == 16'h0000)
      |-> ##2 page_data == 8'h00)
      else $error("warning time not zero");
   chk_crit_zeroed: assert property (settled && page_rd && page_addr > 9'h0C3
      && page_addr < 9'h0C8
      && critical_temp_threshold == 16'h0000 |-> ##2 page_data == 8'h00)
      else $error("critical time not zero");
endmodule

bind health_log_counters health_log_chk i_chk (.ref_clk, .arst_n, .warning_temp_threshold,
   .critical_temp_threshold, .sensor_present, .sensor_temp, .page_rd, .page_addr, .page_data,
   .page_valid);

// file: health_log_counters.sv
// How it works
// RULE1 - Count completed write commands at byte 80
// RULE2 - Read counter counts Compare and Read; the code counts one when both complete in the same cycle
// RULE3 - Busy time accrues while I/O outstanding
// RULE4 - Busy time reported in whole minutes
// RULE5 - Power cycles counted once each
// RULE6 - Power-on hours, non-operational time may skip
// RULE7 - Unsafe shutdown when no prior notification
// RULE8 - Count unrecovered data integrity errors
// RULE9 - Lifetime count of error log entries
// RULE10 - Minutes in warning band while operational
// RULE11 - Warning time zero if threshold zero
// RULE12 - Minutes above critical while operational
// RULE13 - Critical time zero if critical zero
// RULE14 - Sensors one to four at 200..207
// RULE15 - Sensor kelvin value, absent reads zero
// RULE16 - Counters saturate, never wrap
// RULE17 - Prescaled ticks gate the time counters
module health_log_counters
   import health_log_pkg::*;
#(
   parameter longint unsigned MINUTE_TICKS = MINUTE_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Command completion events, one-cycle pulses, and the I/O outstanding level
   input wire logic read_cmd_done,
   input wire logic compare_cmd_done,
   input wire logic write_cmd_done,
   input wire logic io_outstanding,
   // Power events, one-cycle pulses, and the operational level
   input wire logic power_up,
   input wire logic power_loss,
   input wire logic shutdown_notification,
   input wire logic operational,
   // Error events, one-cycle pulses
   input wire logic integrity_error,
   input wire logic error_log_entry,
   // Temperature
   input wire logic [TEMP_W-1:0] composite_temp,
   input wire logic [TEMP_W-1:0] warning_temp_threshold,
   input wire logic [TEMP_W-1:0] critical_temp_threshold,
   input wire logic [SENSOR_COUNT-1:0] sensor_present,
   input wire logic [SENSOR_COUNT*TEMP_W-1:0] sensor_temp,
   // Log page read port
   input wire logic page_rd,
   input wire logic [BYTE_ADDR_W-1:0] page_addr,
   output logic [7:0] page_data,
   output logic page_valid
);
   // ==========================================================
   // Counters
   logic [WIDE_CNT_W-1:0] host_read_cmds;
   logic [WIDE_CNT_W-1:0] host_write_cmds;
   logic [WIDE_CNT_W-1:0] busy_minutes;
   logic [WIDE_CNT_W-1:0] power_cycles;
   logic [WIDE_CNT_W-1:0] power_on_hours;
   logic [WIDE_CNT_W-1:0] unsafe_shutdowns;
   logic [WIDE_CNT_W-1:0] integrity_errors;
   logic [WIDE_CNT_W-1:0] error_log_entries;
   logic [TEMP_TIME_W-1:0] warn_minutes;
   logic [TEMP_TIME_W-1:0] crit_minutes;
   logic [SENSOR_COUNT*TEMP_W-1:0] sensor_reading;
   logic [PRESCALE_W-1:0] prescale;
   logic [HOUR_CNT_W-1:0] minute_of_hour;
   logic minute_tick;
   logic hour_tick;
   logic shutdown_noted;
   logic busy_seen;
   logic warn_seen;
   logic crit_seen;
   logic warn_band;
   logic crit_band;
   logic warn_enabled;
   logic crit_enabled;

   function automatic logic [WIDE_CNT_W-1:0] sat_inc(input logic [WIDE_CNT_W-1:0] v);
      return (&v) ? v : v + WIDE_CNT_W'(1); // RULE16
   endfunction

   function automatic logic [TEMP_TIME_W-1:0] sat_inc32(input logic [TEMP_TIME_W-1:0] v);
      return (&v) ? v : v + TEMP_TIME_W'(1); // RULE16
   endfunction

   // ==========================================================
   // Minute and hour ticks from a free-running prescaler
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prescale <= '0;
         minute_tick <= 1'b0;
      end else if (prescale == PRESCALE_W'(MINUTE_TICKS - 1)) begin
         prescale <= '0; // RULE17
         minute_tick <= 1'b1;
      end else begin
         prescale <= prescale + PRESCALE_W'(1);
         minute_tick <= 1'b0;
      end
   end

   // Hours follow only operational minutes, so idle time is skipped
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         minute_of_hour <= '0;
         hour_tick <= 1'b0;
      end else begin
         hour_tick <= 1'b0;
         if (minute_tick && operational) begin
            if (minute_of_hour == HOUR_LAST) begin
               minute_of_hour <= '0;
               hour_tick <= 1'b1; // RULE6
            end else begin
               minute_of_hour <= minute_of_hour + HOUR_CNT_W'(1);
            end
         end
      end
   end

   // ==========================================================
   // Conditions sampled across each minute, so short spans count
   assign warn_enabled = (warning_temp_threshold != TEMP_ZERO) &&
                         (critical_temp_threshold != TEMP_ZERO); // RULE11
   assign crit_enabled = critical_temp_threshold != TEMP_ZERO; // RULE13
   assign warn_band = operational && warn_enabled && composite_temp >= warning_temp_threshold
                      && composite_temp < critical_temp_threshold; // RULE10
   assign crit_band = operational && crit_enabled &&
                      composite_temp > critical_temp_threshold; // RULE12

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_seen <= 1'b0;
         warn_seen <= 1'b0;
         crit_seen <= 1'b0;
      end else if (minute_tick) begin
         busy_seen <= io_outstanding;
         warn_seen <= warn_band;
         crit_seen <= crit_band;
      end else begin
         busy_seen <= busy_seen | io_outstanding; // RULE3
         warn_seen <= warn_seen | warn_band;
         crit_seen <= crit_seen | crit_band;
      end
   end

   // ==========================================================
   // Command counters
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         host_read_cmds <= WIDE_CNT_RESET;
      end else if (read_cmd_done || compare_cmd_done) begin
         host_read_cmds <= sat_inc(host_read_cmds); // RULE2
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         host_write_cmds <= WIDE_CNT_RESET;
      end else if (write_cmd_done) begin
         host_write_cmds <= sat_inc(host_write_cmds); // RULE1
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_minutes <= WIDE_CNT_RESET;
      end else if (minute_tick && busy_seen) begin
         busy_minutes <= sat_inc(busy_minutes); // RULE4
      end
   end

   // ==========================================================
   // Power counters
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         power_cycles <= WIDE_CNT_RESET;
      end else if (power_up) begin
         power_cycles <= sat_inc(power_cycles); // RULE5
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         power_on_hours <= WIDE_CNT_RESET;
      end else if (hour_tick) begin
         power_on_hours <= sat_inc(power_on_hours); // RULE6
      end
   end

   // Notification stays armed until the next power-up
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         shutdown_noted <= 1'b0;
      end else if (shutdown_notification) begin
         shutdown_noted <= 1'b1;
      end else if (power_up) begin
         shutdown_noted <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         unsafe_shutdowns <= WIDE_CNT_RESET;
      end else if (power_loss && !shutdown_noted && !shutdown_notification) begin
         unsafe_shutdowns <= sat_inc(unsafe_shutdowns); // RULE7
      end
   end

   // ==========================================================
   // Error counters
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         integrity_errors <= WIDE_CNT_RESET;
      end else if (integrity_error) begin
         integrity_errors <= sat_inc(integrity_errors); // RULE8
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         error_log_entries <= WIDE_CNT_RESET;
      end else if (error_log_entry) begin
         error_log_entries <= sat_inc(error_log_entries); // RULE9
      end
   end

   // ==========================================================
   // Temperature band times
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         warn_minutes <= TEMP_TIME_RESET;
      end else if (!warn_enabled) begin
         warn_minutes <= TEMP_TIME_RESET; // RULE11
      end else if (minute_tick && warn_seen) begin
         warn_minutes <= sat_inc32(warn_minutes); // RULE10
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         crit_minutes <= TEMP_TIME_RESET;
      end else if (!crit_enabled) begin
         crit_minutes <= TEMP_TIME_RESET; // RULE13
      end else if (minute_tick && crit_seen) begin
         crit_minutes <= sat_inc32(crit_minutes); // RULE12
      end
   end

   // ==========================================================
   // Sensor readings
   generate
      for (genvar s = 0; s < SENSOR_COUNT; s++) begin : g_sensor
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               sensor_reading[s*TEMP_W +: TEMP_W] <= TEMP_ZERO;
            end else if (sensor_present[s]) begin
               sensor_reading[s*TEMP_W +: TEMP_W] <= sensor_temp[s*TEMP_W +: TEMP_W]; // RULE15
            end else begin
               sensor_reading[s*TEMP_W +: TEMP_W] <= TEMP_ZERO; // RULE15
            end
         end
      end
   endgenerate

   // ==========================================================
   // Page snapshot: one 16-byte word per cycle, sweeping forever
   logic [WORD_ADDR_W-1:0] sweep;
   logic [WIDE_CNT_W-1:0] sweep_data;
   logic [WIDE_CNT_W-1:0] rd_word;
   logic [3:0] lane;
   logic rd_pending;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sweep <= '0;
      end else begin
         sweep <= sweep + WORD_ADDR_W'(1);
      end
   end

   always_comb begin
      sweep_data = WIDE_CNT_RESET;
      if (sweep == WORD_ADDR_W'(HOST_READ_CMD_BYTE / 16)) begin
         sweep_data = host_read_cmds;
      end else if (sweep == WORD_ADDR_W'(HOST_WRITE_CMD_BYTE / 16)) begin
         sweep_data = host_write_cmds; // RULE1
      end else if (sweep == WORD_ADDR_W'(BUSY_TIME_BYTE / 16)) begin
         sweep_data = busy_minutes;
      end else if (sweep == WORD_ADDR_W'(POWER_CYCLE_BYTE / 16)) begin
         sweep_data = power_cycles;
      end else if (sweep == WORD_ADDR_W'(POWER_ON_HOURS_BYTE / 16)) begin
         sweep_data = power_on_hours;
      end else if (sweep == WORD_ADDR_W'(UNSAFE_SHUTDOWN_BYTE / 16)) begin
         sweep_data = unsafe_shutdowns;
      end else if (sweep == WORD_ADDR_W'(INTEGRITY_ERR_BYTE / 16)) begin
         sweep_data = integrity_errors;
      end else if (sweep == WORD_ADDR_W'(ERR_LOG_ENTRY_BYTE / 16)) begin
         sweep_data = error_log_entries;
      end else if (sweep == WORD_ADDR_W'(WARN_TIME_BYTE / 16)) begin
         // Little-endian: warn at 195:192, crit 199:196, sensors 207:200
         sweep_data = {sensor_reading, crit_minutes, warn_minutes}; // RULE14
      end
   end

   health_log_ram u_ram (
      .ref_clk(ref_clk),
      .wr_en(1'b1),
      .wr_addr(sweep),
      .wr_data(sweep_data),
      .rd_addr(page_addr[BYTE_ADDR_W-1:4]),
      .rd_data(rd_word)
   );

   // ==========================================================
   // Byte read: answer two cycles after the request
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         lane <= '0;
         rd_pending <= 1'b0;
         page_data <= 8'h00;
         page_valid <= 1'b0;
      end else begin
         lane <= page_addr[3:0];
         rd_pending <= page_rd;
         page_valid <= rd_pending;
         if (rd_pending) begin
            page_data <= rd_word[{lane, 3'b000} +: 8];
         end
      end
   end
endmodule

// file: health_log_counters_tb_top.sv
module health_log_counters_tb_top;
   import health_log_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Signals
   logic ref_clk = 1'b0;
   logic arst_n;
   logic [7:0] ev;
   logic io_outstanding, operational, go, rd_done, page_rd, page_valid;
   logic [TEMP_W-1:0] composite_temp, warning_temp_threshold, critical_temp_threshold;
   logic [SENSOR_COUNT-1:0] sensor_present;
   logic [SENSOR_COUNT*TEMP_W-1:0] sensor_temp;
   logic [BYTE_ADDR_W-1:0] page_addr, base_addr;
   logic [7:0] page_data;
   logic [4:0] nbytes;
   logic [WIDE_CNT_W-1:0] value;
   logic [WIDE_CNT_W-1:0] expq[$];
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;
   int seed = 32'h46fc;
   int a, b;
   // Short minute keeps the hour test near 1200 cycles
   health_log_counters #(.MINUTE_TICKS(20)) i_dut (.ref_clk, .arst_n, .read_cmd_done(ev[0]),
      .compare_cmd_done(ev[1]), .write_cmd_done(ev[2]), .io_outstanding, .power_up(ev[3]),
      .power_loss(ev[4]), .shutdown_notification(ev[5]), .operational, .integrity_error(ev[6]),
      .error_log_entry(ev[7]), .composite_temp, .warning_temp_threshold,
      .critical_temp_threshold, .sensor_present, .sensor_temp, .page_rd, .page_addr,
      .page_data, .page_valid);
   host_log_reader i_host (.ref_clk, .go, .base_addr, .nbytes, .value, .done(rd_done),
      .page_rd, .page_addr, .page_data, .page_valid);
   always #12.5 ref_clk = ~ref_clk;
   // ==========================================================
   // Tasks
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic note_fail(input string msg);
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask
   task automatic check_field(input logic [WIDE_CNT_W-1:0] got, input logic [WIDE_CNT_W-1:0] exp);
      n_tests++;
      if (got !== exp) note_fail($sformatf("field %0h, expected %0h", got, exp));
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic pulses(input logic [7:0] m, input int n);
      repeat (n) begin
         ev = m;
         @(negedge ref_clk);
      end
      // Quiet cycle so the next burst never rewrites ev in this step
      ev = 8'h00;
      @(negedge ref_clk);
   endtask
   task automatic band(input logic [TEMP_W-1:0] t);
      composite_temp = t;
      operational = 1'b1;
      idle(1);
      operational = 1'b0;
      idle(30);
   endtask
   task automatic read_field(input int addr, input int n, input logic [WIDE_CNT_W-1:0] exp);
      int k;
      idle(40);
      expq.push_back(exp);
      base_addr = BYTE_ADDR_W'(addr);
      nbytes = 5'(n);
      go = 1'b1;
      @(negedge ref_clk);
      go = 1'b0;
      for (k = 0; k < 100 && rd_done !== 1'b1; k++) @(posedge ref_clk);
      if (k == 100) note_fail("no page answer");
      @(negedge ref_clk);
   endtask
   task automatic end_test(input string name);
      $display("test %s ended at %0t", name, $time);
   endtask
   // ==========================================================
   // Watchers
   always @(posedge ref_clk) begin
      if (rd_done === 1'b1) begin
         if (expq.size() == 0) note_fail("answer with no note");
         else check_field(value, expq.pop_front());
      end
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 12000) begin
         note_fail("run hung");
         tally_and_finish();
      end
   end
   // ==========================================================
   // Sequence
   initial begin
      arst_n = 1'b0;
      ev = 8'h00;
      {io_outstanding, operational, go} = 3'h0;
      composite_temp = 16'h012C;
      warning_temp_threshold = 16'h015E;
      critical_temp_threshold = 16'h0172;
      sensor_present = 4'h0;
      sensor_temp = '0;
      idle(5);
      arst_n = 1'b1;
      a = 1 + $unsigned($random(seed)) % 12;
      b = 1 + $unsigned($random(seed)) % 12;
      pulses(8'h04, a);
      read_field(80, 16, a);
      pulses(8'h01, a);
      pulses(8'h02, b);
      pulses(8'h03, 1);
      read_field(64, 16, a + b + 1);
      end_test("commands");
      pulses(8'h08, 3);
      pulses(8'h10, 1);
      pulses(8'h20, 1);
      pulses(8'h10, 1);
      pulses(8'h08, 1);
      pulses(8'h30, 1);
      pulses(8'h08, 1);
      pulses(8'h10, 1);
      read_field(112, 16, 5);
      read_field(144, 16, 2);
      end_test("power");
      pulses(8'h40, a);
      pulses(8'h80, b);
      pulses(8'hC0, 1);
      read_field(160, 16, a + 1);
      read_field(176, 16, b + 1);
      end_test("errors");
      io_outstanding = 1'b1;
      idle(1);
      io_outstanding = 1'b0;
      idle(30);
      io_outstanding = 1'b1;
      idle(1);
      io_outstanding = 1'b0;
      read_field(96, 16, 2);
      end_test("busy");
      band(16'h015E);
      band(16'h0172);
      band(16'h0173);
      read_field(192, 4, 1);
      read_field(196, 4, 1);
      warning_temp_threshold = 16'h0000;
      band(16'h0100);
      read_field(192, 4, 0);
      critical_temp_threshold = 16'h0000;
      band(16'h0173);
      read_field(196, 4, 0);
      end_test("temperature");
      read_field(128, 16, 0);
      operational = 1'b1;
      idle(1210);
      operational = 1'b0;
      read_field(128, 16, 1);
      end_test("hours");
      for (int r = 0; r < 2; r++) begin
         sensor_present = r ? 4'h5 : 4'hA;
         sensor_temp = {$random(seed), $random(seed)};
         for (int s = 0; s < 4; s++) begin
            read_field(200 + 2 * s, 2, sensor_present[s] ? sensor_temp[16*s +: 16] : 16'h0);
         end
      end
      read_field(0, 2, 0);
      read_field(500, 2, 0);
      end_test("sensors");
      tally_and_finish();
   end
endmodule

// file: health_log_pkg.sv
package health_log_pkg;
   // ==========================================================
   // Log page layout (byte offsets of each field's low byte)
   localparam int unsigned HOST_READ_CMD_BYTE = 64;
   localparam int unsigned HOST_WRITE_CMD_BYTE = 80;
   localparam int unsigned BUSY_TIME_BYTE = 96;
   localparam int unsigned POWER_CYCLE_BYTE = 112;
   localparam int unsigned POWER_ON_HOURS_BYTE = 128;
   localparam int unsigned UNSAFE_SHUTDOWN_BYTE = 144;
   localparam int unsigned INTEGRITY_ERR_BYTE = 160;
   localparam int unsigned ERR_LOG_ENTRY_BYTE = 176;
   localparam int unsigned WARN_TIME_BYTE = 192;
   localparam int unsigned CRIT_TIME_BYTE = 196;
   localparam int unsigned SENSOR_BYTE = 200;
   localparam int unsigned SENSOR_BYTES = 2;
   localparam int unsigned PAGE_BYTES = 512;
   localparam int unsigned BYTE_ADDR_W = 9;
   // ==========================================================
   // Field widths
   localparam int unsigned WIDE_CNT_W = 128;
   localparam int unsigned TEMP_TIME_W = 32;
   localparam int unsigned TEMP_W = 16;
   localparam int unsigned SENSOR_COUNT = 4;
   localparam int unsigned PAGE_WORDS = 32;
   localparam int unsigned WORD_ADDR_W = 5;
   // ==========================================================
   // Reset values
   localparam logic [WIDE_CNT_W-1:0] WIDE_CNT_RESET = 128'h0;
   localparam logic [TEMP_TIME_W-1:0] TEMP_TIME_RESET = 32'h0;
   localparam logic [TEMP_W-1:0] TEMP_ZERO = 16'h0;
   // ==========================================================
   // Timing
   localparam longint unsigned CLOCK_HZ = 40000000;
   localparam longint unsigned MINUTE_S = 60;
   localparam longint unsigned HOUR_MIN = 60;
   localparam longint unsigned MINUTE_CYCLES = CLOCK_HZ * MINUTE_S;
   localparam int unsigned PRESCALE_W = 32;
   localparam int unsigned HOUR_CNT_W = 6;
   localparam logic [HOUR_CNT_W-1:0] HOUR_LAST = 6'(HOUR_MIN - 1);
endpackage

// file: health_log_ram.sv
module health_log_ram
   import health_log_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Write port
   input wire logic wr_en,
   input wire logic [WORD_ADDR_W-1:0] wr_addr,
   input wire logic [WIDE_CNT_W-1:0] wr_data,
   // Read port
   input wire logic [WORD_ADDR_W-1:0] rd_addr,
   output logic [WIDE_CNT_W-1:0] rd_data
);
   // ==========================================================
   // Snapshot of the page in 16-byte words, no reset needed
   logic [WIDE_CNT_W-1:0] mem [PAGE_WORDS];

   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule

// file: host_log_reader.sv
module host_log_reader
   import health_log_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Command from the bench
   input wire logic go,
   input wire logic [BYTE_ADDR_W-1:0] base_addr,
   input wire logic [4:0] nbytes,
   output logic [WIDE_CNT_W-1:0] value,
   output logic done,
   // Log page read port
   output logic page_rd,
   output logic [BYTE_ADDR_W-1:0] page_addr,
   input wire logic [7:0] page_data,
   input wire logic page_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   int got = 0;
   initial begin
      page_rd = 1'b0;
      page_addr = '0;
      value = '0;
      done = 1'b0;
   end
   // ==========================================================
   // Back-to-back byte requests, gathered low byte first
   always begin
      @(posedge ref_clk iff go);
      @(negedge ref_clk);
      value = '0;
      got = 0;
      for (int i = 0; i < nbytes; i++) begin
         page_rd = 1'b1;
         page_addr = base_addr + BYTE_ADDR_W'(i);
         @(negedge ref_clk);
      end
      page_rd = 1'b0;
      // Idle address toggles so a stale value never looks valid
      page_addr = ~page_addr;
      while (got < nbytes) @(negedge ref_clk);
      done = 1'b1;
      @(negedge ref_clk);
      done = 1'b0;
   end
   always @(posedge ref_clk) begin
      if (page_valid === 1'b1 && got < 16) begin
         value[8*got +: 8] = page_data;
         got = got + 1;
      end
   end
endmodule
